/* tfsr_params.svh */
`ifndef TFSR_PARAMS_SVH
`define TFSR_PARAMS_SVH
`define TFSR_OFS_PART_ID 8'h3d
`define TFSR_OFS_MAKER_ID 8'h3e
`define TFSR_OFS_REVISION 8'h3f
`define TFSR_OFS_LOCAL_LO 8'h40
`define TFSR_OFS_LOCAL_HI 8'h41
`define TFSR_OFS_REMOTE_LO 8'h42
`define TFSR_OFS_REMOTE_HI 8'h43
`define TFSR_OFS_FAN_LO 8'h4a
`define TFSR_OFS_FAN_HI 8'h4b
`define TFSR_OFS_DUTY 8'h4e
`define TFSR_OFS_STAT1 8'h4f
`define TFSR_OFS_STAT2 8'h50
`define TFSR_OFS_STAT3 8'h51
`define TFSR_RST_ZERO 8'h00
`define TFSR_RST_FAN 16'hffff
`define TFSR_RST_DUTY_LIMIT 8'hff
`define TFSR_FRAC_W 5
`define TFSR_TEMP_W 13
`define TFSR_BIT_HI_LOCAL 7
`define TFSR_BIT_LO_LOCAL 6
`define TFSR_BIT_HI_REMOTE 5
`define TFSR_BIT_LO_REMOTE 4
`define TFSR_BIT_DIODE 3
`define TFSR_BIT_OVL_LOCAL 7
`define TFSR_BIT_OVL_REMOTE 6
`define TFSR_BIT_ONTIME 4
`define TFSR_BIT_OVL_IN 3
`define TFSR_BIT_OVL_OUT 2
`define TFSR_BIT_STALL 7
`define TFSR_BIT_ALARM 6
`define TFSR_BIT_ALERT 0
`endif

/* tfsr_pkg.sv */
package tfsr_pkg;
  typedef logic [7:0] tfsr_byte_t;
  typedef logic [12:0] tfsr_temp_t;
endpackage

/* tfsr_sync.sv */
`timescale 1ns/1ns
// two flip-flop synchroniser for pin levels
module tfsr_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tfsr_sync_s;
  tfsr_sync_s st_q;
  tfsr_sync_s st_d;
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule

/* tfsr_regs.sv */
`timescale 1ns/1ns
`include "tfsr_params.svh"
module tfsr_regs #(
  parameter logic [7:0] PART_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'ha5, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01    // arbitrary value
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SW_RESET,
  input wire logic MEAS_VALID,
  input wire logic [12:0] LOCAL_TEMP,
  input wire logic [12:0] REMOTE_TEMP,
  input wire logic DIODE_CHECKED,
  input wire logic DIODE_FAULT,
  input wire logic FAN_PERIOD_VALID,
  input wire logic [15:0] FAN_PERIOD,
  input wire logic DUTY_VALID,
  input wire logic [7:0] DUTY_PERCENT,
  input wire logic DUTY_LIMIT_WE,
  input wire logic [7:0] DUTY_LIMIT_WDATA,
  input wire logic LOCAL_HIGH_TRIP,
  input wire logic LOCAL_LOW_TRIP,
  input wire logic REMOTE_HIGH_TRIP,
  input wire logic REMOTE_LOW_TRIP,
  input wire logic LOCAL_OVL_TRIP,
  input wire logic REMOTE_OVL_TRIP,
  input wire logic OVL_LINE_IN_N,
  input wire logic OVL_LINE_DRIVE,
  input wire logic FAN_STALL,
  input wire logic FAN_ALARM_SPEED,
  input wire logic ALERT_DRIVE,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic [7:0] DUTY_LIMIT
);
  typedef struct packed {
    tfsr_pkg::tfsr_temp_t local_t;
    tfsr_pkg::tfsr_temp_t remote_t;
    logic [15:0] fan;
    logic [7:0] duty;
    logic [7:0] limit;
    logic diode;
    logic ontime;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;
    logic [7:0] rdata;
    logic rvalid;
  } tfsr_regs_s;

  tfsr_regs_s st_q;
  tfsr_regs_s st_d;
  logic pin_low;
  tfsr_pkg::tfsr_byte_t rd_mux;
  logic ontime_set;
  logic rd_st2;

  // pin level is asynchronous to CLK
  tfsr_sync #(.W(1)) u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .d(~OVL_LINE_IN_N),
    .q(pin_low)
  );

  assign rd_st2 = RD_EN && (ADDR == `TFSR_OFS_STAT2);
  // zero limit also sets the flag whenever the overlimit line is low, from the pin or our own drive
  assign ontime_set = (DUTY_VALID && (DUTY_PERCENT > st_q.limit)) ||
                      ((st_q.limit == 8'h00) && (pin_low || OVL_LINE_DRIVE));

  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      `TFSR_OFS_PART_ID: rd_mux = PART_ID;
      `TFSR_OFS_MAKER_ID: rd_mux = MAKER_ID;
      `TFSR_OFS_REVISION: rd_mux = REV_ID;
      `TFSR_OFS_LOCAL_LO: rd_mux = {3'h0, st_q.local_t[4:0]};
      `TFSR_OFS_LOCAL_HI: rd_mux = st_q.local_t[12:5];
      `TFSR_OFS_REMOTE_LO: rd_mux = {3'h0, st_q.remote_t[4:0]};
      `TFSR_OFS_REMOTE_HI: rd_mux = st_q.remote_t[12:5];
      `TFSR_OFS_FAN_LO: rd_mux = st_q.fan[7:0];
      `TFSR_OFS_FAN_HI: rd_mux = st_q.fan[15:8];
      `TFSR_OFS_DUTY: rd_mux = st_q.duty;
      `TFSR_OFS_STAT1: rd_mux = st_q.st1;
      `TFSR_OFS_STAT2: rd_mux = st_q.st2;
      `TFSR_OFS_STAT3: rd_mux = st_q.st3;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    // writes on the register port never alter this bank
    if (WR_EN) begin
      st_d.rdata = st_q.rdata;
    end
    if (MEAS_VALID) begin
      st_d.local_t = LOCAL_TEMP;
      st_d.remote_t = REMOTE_TEMP;
    end
    if (DIODE_CHECKED) begin
      st_d.diode = DIODE_FAULT;
    end
    if (FAN_PERIOD_VALID) begin
      st_d.fan = FAN_PERIOD;
    end
    if (DUTY_VALID) begin
      st_d.duty = DUTY_PERCENT;
    end
    if (DUTY_LIMIT_WE) begin
      st_d.limit = DUTY_LIMIT_WDATA;
    end
    // set wins over the read clear so a coincident event is kept
    if (ontime_set) begin
      st_d.ontime = 1'b1;
    end else if (rd_st2) begin
      st_d.ontime = 1'b0;
    end
    st_d.st1 = 8'h00;
    st_d.st1[`TFSR_BIT_HI_LOCAL] = LOCAL_HIGH_TRIP;
    st_d.st1[`TFSR_BIT_LO_LOCAL] = LOCAL_LOW_TRIP;
    st_d.st1[`TFSR_BIT_HI_REMOTE] = REMOTE_HIGH_TRIP;
    st_d.st1[`TFSR_BIT_LO_REMOTE] = REMOTE_LOW_TRIP;
    st_d.st1[`TFSR_BIT_DIODE] = st_d.diode;
    st_d.st2 = 8'h00;
    st_d.st2[`TFSR_BIT_OVL_LOCAL] = LOCAL_OVL_TRIP;
    st_d.st2[`TFSR_BIT_OVL_REMOTE] = REMOTE_OVL_TRIP;
    st_d.st2[`TFSR_BIT_ONTIME] = st_d.ontime;
    // only an outside driver counts, not our own pull-down
    st_d.st2[`TFSR_BIT_OVL_IN] = pin_low && !OVL_LINE_DRIVE;
    st_d.st2[`TFSR_BIT_OVL_OUT] = OVL_LINE_DRIVE;
    st_d.st3 = 8'h00;
    st_d.st3[`TFSR_BIT_STALL] = FAN_STALL;
    st_d.st3[`TFSR_BIT_ALARM] = FAN_ALARM_SPEED;
    st_d.st3[`TFSR_BIT_ALERT] = ALERT_DRIVE;
    st_d.rdata = RD_EN ? rd_mux : 8'h00;
    st_d.rvalid = RD_EN;
    if (SW_RESET) begin
      st_d.local_t = 13'h0000;
      st_d.remote_t = 13'h0000;
      st_d.fan = `TFSR_RST_FAN;
      st_d.duty = `TFSR_RST_ZERO;
      st_d.diode = 1'b0;
      st_d.ontime = 1'b0;
      st_d.st1 = `TFSR_RST_ZERO;
      st_d.st2 = `TFSR_RST_ZERO;
      st_d.st3 = `TFSR_RST_ZERO;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= '0;
      st_q.fan <= `TFSR_RST_FAN;
      st_q.limit <= `TFSR_RST_DUTY_LIMIT;
    end else begin
      st_q <= st_d;
    end
  end

  assign RDATA = st_q.rdata;
  assign RVALID = st_q.rvalid;
  assign DUTY_LIMIT = st_q.limit;

  property p_fan_reset;
    @(posedge CLK) disable iff (!RESETN) SW_RESET |=> (st_q.fan == 16'hffff);
  endproperty
  a_fan_reset: assert property (p_fan_reset) else $error("fan period not all ones after reset");
  property p_ontime_clear;
    @(posedge CLK) disable iff (!RESETN) (rd_st2 && !ontime_set && !SW_RESET) |=> !st_q.ontime;
  endproperty
  a_ontime_clear: assert property (p_ontime_clear) else $error("on-time flag survived read");
  property p_ontime_zero;
    @(posedge CLK) disable iff (!RESETN)
      (st_q.limit == 8'h00 && OVL_LINE_DRIVE && !SW_RESET) |=> st_q.st2[4];
  endproperty
  a_ontime_zero: assert property (p_ontime_zero) else $error("zero limit flag not reasserted");
  property p_out_flag;
    @(posedge CLK) disable iff (!RESETN) (OVL_LINE_DRIVE && !SW_RESET) |=> st_q.st2[2] && !st_q.st2[3];
  endproperty
  a_out_flag: assert property (p_out_flag) else $error("output drive flag wrong");
  property p_read_local;
    @(posedge CLK) disable iff (!RESETN)
      (RD_EN && ADDR == 8'h41) |=> (RDATA == $past(st_q.local_t[12:5]) && RVALID);
  endproperty
  a_read_local: assert property (p_read_local) else $error("local integer read wrong");
  property p_reserved;
    @(posedge CLK) disable iff (!RESETN) (st_q.st2[1:0] == 2'b00) && (st_q.st3[5:1] == 5'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_stall;
    @(posedge CLK) disable iff (!RESETN) (FAN_STALL && !SW_RESET) |=> st_q.st3[7];
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag missing");
  property p_alert;
    @(posedge CLK) disable iff (!RESETN) (!ALERT_DRIVE && !SW_RESET) |=> !st_q.st3[0];
  endproperty
  a_alert: assert property (p_alert) else $error("alert flag stale");
  // a read is taken on one edge and its answer stands on the next edge only
  sequence s_rd_local_lo;
    RD_EN && (ADDR == `TFSR_OFS_LOCAL_LO);
  endsequence
  sequence s_rd_remote_lo;
    RD_EN && (ADDR == `TFSR_OFS_REMOTE_LO);
  endsequence
  sequence s_rd_remote_hi;
    RD_EN && (ADDR == `TFSR_OFS_REMOTE_HI);
  endsequence
  sequence s_rd_fan_lo;
    RD_EN && (ADDR == `TFSR_OFS_FAN_LO);
  endsequence
  sequence s_rd_fan_hi;
    RD_EN && (ADDR == `TFSR_OFS_FAN_HI);
  endsequence
  sequence s_rd_duty;
    RD_EN && (ADDR == `TFSR_OFS_DUTY);
  endsequence
  sequence s_rd_ids;
    RD_EN && (ADDR == `TFSR_OFS_PART_ID);
  endsequence
  sequence s_rd_hole;
    RD_EN && (ADDR inside {[8'h44:8'h49], 8'h4c, 8'h4d});
  endsequence
  sequence s_no_read;
    !RD_EN;
  endsequence
  property p_read_local_frac;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_local_lo |=> (RVALID && (RDATA == {3'h0, $past(st_q.local_t[4:0])}));
  endproperty
  a_read_local_frac: assert property (p_read_local_frac) else $error("local fraction read wrong");
  property p_read_remote_frac;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_remote_lo |=> (RVALID && (RDATA == {3'h0, $past(st_q.remote_t[4:0])}));
  endproperty
  a_read_remote_frac: assert property (p_read_remote_frac) else $error("remote fraction read wrong");
  property p_read_remote_int;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_remote_hi |=> (RVALID && (RDATA == $past(st_q.remote_t[12:5])));
  endproperty
  a_read_remote_int: assert property (p_read_remote_int) else $error("remote integer read wrong");
  property p_read_fan_lo;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_fan_lo |=> (RVALID && (RDATA == $past(st_q.fan[7:0])));
  endproperty
  a_read_fan_lo: assert property (p_read_fan_lo) else $error("fan low byte read wrong");
  property p_read_fan_hi;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_fan_hi |=> (RVALID && (RDATA == $past(st_q.fan[15:8])));
  endproperty
  a_read_fan_hi: assert property (p_read_fan_hi) else $error("fan high byte read wrong");
  property p_read_duty;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_duty |=> (RVALID && (RDATA == $past(st_q.duty)));
  endproperty
  a_read_duty: assert property (p_read_duty) else $error("duty read wrong");
  property p_read_ident;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_ids |=> (RVALID && (RDATA == PART_ID));
  endproperty
  a_read_ident: assert property (p_read_ident) else $error("identity read wrong");
  property p_read_hole;
    @(posedge CLK) disable iff (!RESETN)
      s_rd_hole |=> (RVALID && (RDATA == 8'h00));
  endproperty
  a_read_hole: assert property (p_read_hole) else $error("unmapped read not zero");
  property p_idle_bus;
    @(posedge CLK) disable iff (!RESETN)
      s_no_read |=> (!RVALID && (RDATA == 8'h00));
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("answer without a read");
  property p_local_trips;
    @(posedge CLK) disable iff (!RESETN)
      !SW_RESET |=> (st_q.st1[7] == $past(LOCAL_HIGH_TRIP)) && (st_q.st1[6] == $past(LOCAL_LOW_TRIP));
  endproperty
  a_local_trips: assert property (p_local_trips) else $error("local trip flags wrong");
  property p_remote_trips;
    @(posedge CLK) disable iff (!RESETN)
      !SW_RESET |=> (st_q.st1[5] == $past(REMOTE_HIGH_TRIP)) && (st_q.st1[4] == $past(REMOTE_LOW_TRIP));
  endproperty
  a_remote_trips: assert property (p_remote_trips) else $error("remote trip flags wrong");
  property p_diode;
    @(posedge CLK) disable iff (!RESETN)
      (DIODE_CHECKED && !SW_RESET) |=> (st_q.st1[3] == $past(DIODE_FAULT));
  endproperty
  a_diode: assert property (p_diode) else $error("diode flag wrong");
  property p_ovl_trips;
    @(posedge CLK) disable iff (!RESETN)
      !SW_RESET |=> (st_q.st2[7] == $past(LOCAL_OVL_TRIP)) && (st_q.st2[6] == $past(REMOTE_OVL_TRIP));
  endproperty
  a_ovl_trips: assert property (p_ovl_trips) else $error("overlimit trip flags wrong");
  property p_ontime_set;
    @(posedge CLK) disable iff (!RESETN)
      (DUTY_VALID && (DUTY_PERCENT > st_q.limit) && !SW_RESET) |=> (st_q.ontime && st_q.st2[4]);
  endproperty
  a_ontime_set: assert property (p_ontime_set) else $error("on-time flag not set");
  property p_ontime_hold;
    @(posedge CLK) disable iff (!RESETN)
      (st_q.ontime && !rd_st2 && !SW_RESET) |=> st_q.ontime;
  endproperty
  a_ontime_hold: assert property (p_ontime_hold) else $error("on-time flag lost without read");
  property p_in_flag;
    @(posedge CLK) disable iff (!RESETN)
      !SW_RESET |=> (st_q.st2[3] == ($past(pin_low) && !$past(OVL_LINE_DRIVE)));
  endproperty
  a_in_flag: assert property (p_in_flag) else $error("input drive flag wrong");
  property p_alarm;
    @(posedge CLK) disable iff (!RESETN)
      !SW_RESET |=> (st_q.st3[6] == $past(FAN_ALARM_SPEED));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm speed flag wrong");
  property p_alert_set;
    @(posedge CLK) disable iff (!RESETN)
      (ALERT_DRIVE && !SW_RESET) |=> st_q.st3[0];
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert flag missing");
  property p_soft_reset;
    @(posedge CLK) disable iff (!RESETN)
      SW_RESET |=> (st_q.local_t == 13'h0000) && (st_q.remote_t == 13'h0000) && (st_q.duty == 8'h00) &&
        (st_q.st1 == 8'h00) && (st_q.st2 == 8'h00) && (st_q.st3 == 8'h00) && !st_q.ontime;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset left state");
  property p_limit_load;
    @(posedge CLK) disable iff (!RESETN)
      DUTY_LIMIT_WE |=> (DUTY_LIMIT == $past(DUTY_LIMIT_WDATA));
  endproperty
  a_limit_load: assert property (p_limit_load) else $error("limit not loaded");
  property p_limit_keep;
    @(posedge CLK) disable iff (!RESETN)
      !DUTY_LIMIT_WE |=> $stable(DUTY_LIMIT);
  endproperty
  a_limit_keep: assert property (p_limit_keep) else $error("limit changed without load");
endmodule

/* tfsr_host.sv */
`timescale 1ns/1ns
// host side: strobe held through the taking edge, answer read while it stands
module tfsr_host (
  input wire logic CLK,
  output logic RD_EN,
  output logic WR_EN,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic RVALID
);
  initial begin
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge CLK);
    RD_EN = 1'b1;
    ADDR = a;
    @(negedge CLK);
    d = RDATA;
    v = RVALID;
    RD_EN = 1'b0;
    // released address flips so a stale decode is not hidden
    ADDR = ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    WR_EN = 1'b1;
    ADDR = a;
    WDATA = d;
    @(negedge CLK);
    WR_EN = 1'b0;
    WDATA = ~d;
  endtask
endmodule

/* thermal_fan_status_regs_tb.sv */
`timescale 1ns/1ns
module thermal_fan_status_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sw_reset = 1'b0;
  logic ovl_in_n = 1'b1;
  logic [9:0] lv = 10'h000;
  logic [4:0] p = 5'h00;
  logic [12:0] loc_t = 13'h0000;
  logic [12:0] rem_t = 13'h0000;
  logic diode_fault = 1'b0;
  logic [15:0] fan = 16'h0000;
  logic [7:0] duty = 8'h00;
  logic [7:0] lim = 8'h00;
  logic rd_en, wr_en, rvalid;
  logic [7:0] addr, wdata, rdata, duty_limit;
  int miscompares = 0;
  int checks = 0;
  always #4 clk = ~clk;
  tfsr_host u_host (.CLK(clk), .RD_EN(rd_en), .WR_EN(wr_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
    .RVALID(rvalid));
  // identity values are arbitrary
  tfsr_regs #(.PART_ID(8'h6c), .MAKER_ID(8'h93), .REV_ID(8'h2e)) u_dut (.CLK(clk), .RESETN(rst_n),
    .SW_RESET(sw_reset), .MEAS_VALID(p[0]), .LOCAL_TEMP(loc_t), .REMOTE_TEMP(rem_t), .DIODE_CHECKED(p[1]),
    .DIODE_FAULT(diode_fault), .FAN_PERIOD_VALID(p[2]), .FAN_PERIOD(fan), .DUTY_VALID(p[3]),
    .DUTY_PERCENT(duty), .DUTY_LIMIT_WE(p[4]), .DUTY_LIMIT_WDATA(lim), .LOCAL_HIGH_TRIP(lv[0]),
    .LOCAL_LOW_TRIP(lv[1]), .REMOTE_HIGH_TRIP(lv[2]), .REMOTE_LOW_TRIP(lv[3]), .LOCAL_OVL_TRIP(lv[4]),
    .REMOTE_OVL_TRIP(lv[5]), .OVL_LINE_IN_N(ovl_in_n), .OVL_LINE_DRIVE(lv[6]), .FAN_STALL(lv[7]),
    .FAN_ALARM_SPEED(lv[8]), .ALERT_DRIVE(lv[9]), .RD_EN(rd_en), .WR_EN(wr_en), .ADDR(addr),
    .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid), .DUTY_LIMIT(duty_limit));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic pulse(input int i);
    @(negedge clk);
    p[i] = 1'b1;
    @(negedge clk);
    p[i] = 1'b0;
  endtask
  // pin input passes a synchroniser, so levels get time to settle
  task automatic set_lv(input logic [9:0] v, input logic pin_n);
    @(negedge clk);
    lv = v;
    ovl_in_n = pin_n;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    logic [7:0] a[14] = '{8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4a, 8'h4b, 8'h4e, 8'h4f, 8'h50,
      8'h51, 8'h44};
    logic [7:0] e[14] = '{8'h6c, 8'h93, 8'h2e, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    chk("limit", 8'hff, duty_limit);
    for (int i = 0; i < 14; i++) rdchk(a[i], e[i]);
  endtask
  task automatic t_meas;
    loc_t = 13'h1abc;
    rem_t = 13'h0a53;
    fan = 16'h1234;
    duty = 8'h37;
    pulse(0);
    pulse(2);
    pulse(3);
    u_host.wr(8'h40, 8'h00);
    rdchk(8'h40, 8'h1c);
    rdchk(8'h41, 8'hd5);
    rdchk(8'h42, 8'h13);
    rdchk(8'h43, 8'h52);
    rdchk(8'h4a, 8'h34);
    rdchk(8'h4b, 8'h12);
    rdchk(8'h4e, 8'h37);
  endtask
  task automatic t_flags;
    diode_fault = 1'b1;
    pulse(1);
    set_lv(10'h155, 1'b1);
    rdchk(8'h4f, 8'ha8);
    rdchk(8'h50, 8'h84);
    rdchk(8'h51, 8'h40);
    diode_fault = 1'b0;
    pulse(1);
    set_lv(10'h2aa, 1'b0);
    rdchk(8'h4f, 8'h50);
    rdchk(8'h50, 8'h48);
    rdchk(8'h51, 8'h81);
    set_lv(10'h000, 1'b1);
    rdchk(8'h4f, 8'h00);
    rdchk(8'h51, 8'h00);
  endtask
  task automatic t_ontime;
    lim = 8'h10;
    pulse(4);
    chk("limit", 8'h10, duty_limit);
    duty = 8'h10;
    pulse(3);
    rdchk(8'h50, 8'h00);
    duty = 8'h11;
    pulse(3);
    u_host.wr(8'h50, 8'h00);
    rdchk(8'h50, 8'h10);
    rdchk(8'h50, 8'h00);
    lim = 8'h00;
    pulse(4);
    set_lv(10'h040, 1'b1);
    rdchk(8'h50, 8'h14);
    rdchk(8'h50, 8'h14);
    set_lv(10'h000, 1'b1);
  endtask
  task automatic t_swreset;
    @(negedge clk);
    sw_reset = 1'b1;
    @(negedge clk);
    sw_reset = 1'b0;
    rdchk(8'h40, 8'h00);
    rdchk(8'h43, 8'h00);
    rdchk(8'h4e, 8'h00);
    rdchk(8'h4a, 8'hff);
    rdchk(8'h4b, 8'hff);
    rdchk(8'h3d, 8'h6c);
    rdchk(8'h50, 8'h00);
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_meas();
    t_flags();
    t_ontime();
    t_swreset();
    report_and_stop();
  end
endmodule
